// file: mfa_defines.svh
// Constants of the field access engine: register map, fields, codes.
// Included by the package, the engine and the bench; definitions only.
`ifndef MFA_DEFINES_SVH
`define MFA_DEFINES_SVH

`define MFA_A_CTRL 8'h00
`define MFA_A_FIELD 8'h04
`define MFA_A_ADDR 8'h08
`define MFA_A_WDATA 8'h0c
`define MFA_A_VALUE 8'h10
`define MFA_A_RAW 8'h14
`define MFA_A_RESULT 8'h18
`define MFA_A_ISTAT 8'h1c
`define MFA_A_IMASK 8'h20

`define MFA_CTRL_START 0
`define MFA_CTRL_DIR 1
`define MFA_CTRL_SPACE 3:2
`define MFA_CTRL_W32 4
`define MFA_CTRL_FORCE 5
`define MFA_CTRL_FMT 7:6
`define MFA_FLD_CNT 5:0
`define MFA_FLD_POS 13:8
`define MFA_RES_FAULT 15:8

`define MFA_W16 6'd16
`define MFA_W32 6'd32
`define MFA_QTY1 2'd1
`define MFA_QTY2 2'd2

`define MFA_SP_HOLD 2'h2
`define MFA_SP_INP 2'h3

`define MFA_FC_RD_HOLD 8'h03
`define MFA_FC_RD_INP 8'h04
`define MFA_FC_WR_ONE 8'h06
`define MFA_FC_WR_MULTI 8'h10

`define MFA_FAULT_NONE 8'h00
`define MFA_FAULT_SPACE 8'hf0

`define MFA_IRQ_DONE 0
`define MFA_IRQ_FAULT 1
`define MFA_IRQ_REJ 2

`define MFA_RESP_OK 2'b00
`define MFA_RESP_SLVERR 2'b10

`endif

// file: mfa_field_access.sv
// Field access engine of a register client: AXI4-Lite registers,
// request/response port towards the link transport, one interrupt.
// Assumes the transport answers each request exactly once.
// Behaviour
// - 16-bit width: bit count 0 to 16
// - Zero bit count becomes the width maximum
// - 16-bit width: start bit 0 to 15
// - Overlong field trimmed to width minus start
// - Zero bit count forces start bit zero
// - Field is count bits from start
// - Input register reads use code 04
// - 16-bit holding writes use code 06
// - Holding register reads use code 03
// - 32-bit writes use code 16, two registers
// - 32-bit values big-endian, high word first
// - Force option makes 16-bit writes code 16
`timescale 1ns/100ps
`include "mfa_defines.svh"
module mfa_field_access import mfa_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic lnk_req_valid,
    input wire logic lnk_req_ready,
    output logic [7:0] lnk_req_func,
    output logic [15:0] lnk_req_addr,
    output logic [1:0] lnk_req_qty,
    output logic [15:0] lnk_req_data_hi,
    output logic [15:0] lnk_req_data_lo,
    input wire logic lnk_rsp_valid,
    input wire logic lnk_rsp_error,
    input wire logic [7:0] lnk_rsp_code,
    input wire logic [15:0] lnk_rsp_data_hi,
    input wire logic [15:0] lnk_rsp_data_lo,
    output logic irq
);
    mfa_regs_t q;
    mfa_regs_t d;
    logic aw_take, w_take, ar_take, do_wr, busy;
    logic rsp_take, rd_ok, rsp_bad, fld_acc;
    logic [7:0] wa;
    logic [31:0] wv, cv, fv, rsp_word, fld_val, fld_merged;
    logic [3:0] ws;
    logic [11:0] nf;
    logic [41:0] wr;

    function automatic logic [5:0] width_of(input logic w32);
        return w32 ? `MFA_W32 : `MFA_W16;
    endfunction

    function automatic logic fld_ok(input logic [5:0] c, input logic [5:0] p, input logic w32);
        return (c <= width_of(w32)) && (p < width_of(w32));
    endfunction

    // Returns {count, start} after the zero and overflow fix-ups
    function automatic logic [11:0] norm(input logic [5:0] c, input logic [5:0] p, input logic w32);
        logic [5:0] m;
        m = width_of(w32);
        if (c == '0) begin
            return {m, 6'h00};
        end
        if (({1'b0, c} + {1'b0, p}) > {1'b0, m}) begin
            return {6'(m - p), p};
        end
        return {c, p};
    endfunction

    // Returns {func, qty, hi, lo} for writing val
    function automatic logic [41:0] wr_req(input logic w32, input logic frc, input logic [31:0] val);
        if (w32) begin
            return {`MFA_FC_WR_MULTI, `MFA_QTY2, val[31:16], val[15:0]};
        end
        if (frc) begin
            return {`MFA_FC_WR_MULTI, `MFA_QTY1, val[15:0], 16'h0000};
        end
        return {`MFA_FC_WR_ONE, `MFA_QTY1, val[15:0], 16'h0000};
    endfunction

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // First register carries the high word
    assign rsp_word = q.w32 ? {lnk_rsp_data_hi, lnk_rsp_data_lo} : {16'h0000, lnk_rsp_data_hi};

    mfa_field_unit u_field (
        .raw(rsp_word),
        .start(q.field_start_bit),
        .count(q.field_bit_count),
        .ins(q.wdata),
        .extracted(fld_val),
        .merged(fld_merged)
    );

    always_comb begin
        d = q;
        busy = (q.fsm != S_IDLE) || q.go;
        aw_take = s_axi_awvalid && !q.aw_have && !q.bvalid;
        w_take = s_axi_wvalid && !q.w_have && !q.bvalid;
        ar_take = s_axi_arvalid && !q.rvalid;
        wa = q.aw_have ? q.awaddr : s_axi_awaddr;
        wv = q.w_have ? q.wdat : s_axi_wdata;
        ws = q.w_have ? q.wstrb : s_axi_wstrb;
        do_wr = (q.aw_have || aw_take) && (q.w_have || w_take);
        cv = wmerge({24'h000000, q.value_format, q.force_multi_write, q.w32, q.space, q.dir, 1'b0}, wv, ws);
        fv = wmerge({18'h0, q.field_start_bit, 2'b00, q.field_bit_count}, wv, ws);
        nf = norm(fv[`MFA_FLD_CNT], fv[`MFA_FLD_POS], q.w32);
        fld_acc = 1'b0;
        rsp_take = lnk_rsp_valid && ((q.fsm == S_RDWAIT) || (q.fsm == S_WRWAIT));
        rd_ok = rsp_take && !lnk_rsp_error && (q.fsm == S_RDWAIT);
        rsp_bad = rsp_take && lnk_rsp_error;
        wr = wr_req(q.w32, q.force_multi_write, fld_merged);
        // Bus write channels
        if (aw_take) begin
            d.aw_have = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (w_take) begin
            d.w_have = 1'b1;
            d.wdat = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (do_wr) begin
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = `MFA_RESP_OK;
            unique case (wa)
                // Config is frozen while a transaction runs
                `MFA_A_CTRL: begin
                    if (!busy) begin
                        d.dir = cv[`MFA_CTRL_DIR];
                        d.space = cv[`MFA_CTRL_SPACE];
                        d.w32 = cv[`MFA_CTRL_W32];
                        d.force_multi_write = cv[`MFA_CTRL_FORCE];
                        d.value_format = cv[`MFA_CTRL_FMT];
                        d.go = cv[`MFA_CTRL_START];
                        if (cv[`MFA_CTRL_W32] != q.w32) begin
                            {d.field_bit_count, d.field_start_bit} = norm('0, '0, cv[`MFA_CTRL_W32]);
                        end
                    end
                end
                `MFA_A_FIELD: begin
                    if (!busy) begin
                        if (fld_ok(fv[`MFA_FLD_CNT], fv[`MFA_FLD_POS], q.w32)) begin
                            fld_acc = 1'b1;
                            {d.field_bit_count, d.field_start_bit} = nf;
                        end else begin
                            d.irq_status[`MFA_IRQ_REJ] = 1'b1;
                        end
                    end
                end
                `MFA_A_ADDR: begin
                    if (!busy) begin
                        d.reg_addr = 16'(wmerge({16'h0000, q.reg_addr}, wv, ws));
                    end
                end
                `MFA_A_WDATA: begin
                    if (!busy) begin
                        d.wdata = wmerge(q.wdata, wv, ws);
                    end
                end
                `MFA_A_ISTAT: begin
                    d.irq_status = d.irq_status & ~(wv[2:0] & {3{ws[0]}});
                end
                `MFA_A_IMASK: begin
                    if (ws[0]) begin
                        d.irq_mask = wv[2:0];
                    end
                end
                `MFA_A_VALUE, `MFA_A_RAW, `MFA_A_RESULT: begin
                end
                default: begin
                    d.bresp = `MFA_RESP_SLVERR;
                end
            endcase
        end
        // Bus read channel
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (ar_take) begin
            d.rvalid = 1'b1;
            d.rresp = `MFA_RESP_OK;
            unique case (s_axi_araddr)
                `MFA_A_CTRL: d.rdata = {24'h000000, q.value_format, q.force_multi_write, q.w32, q.space, q.dir, 1'b0};
                `MFA_A_FIELD: d.rdata = {18'h0, q.field_start_bit, 2'b00, q.field_bit_count};
                `MFA_A_ADDR: d.rdata = {16'h0000, q.reg_addr};
                `MFA_A_WDATA: d.rdata = q.wdata;
                `MFA_A_VALUE: d.rdata = q.value;
                `MFA_A_RAW: d.rdata = q.unprocessed_reading;
                `MFA_A_RESULT: d.rdata = {15'h0, busy, q.fault_code, 7'h00, q.reading_valid_flag};
                `MFA_A_ISTAT: d.rdata = {29'h0, q.irq_status};
                `MFA_A_IMASK: d.rdata = {29'h0, q.irq_mask};
                default: begin
                    d.rdata = 32'h00000000;
                    d.rresp = `MFA_RESP_SLVERR;
                end
            endcase
        end
        // Transaction sequencer; event bits set after the clears above
        unique case (q.fsm)
            S_IDLE: begin
                if (q.go) begin
                    d.go = 1'b0;
                    d.reading_valid_flag = 1'b0;
                    if (!(q.space == `MFA_SP_HOLD || (q.space == `MFA_SP_INP && !q.dir))) begin
                        // Only holding registers and input register reads are served here
                        d.fault_code = `MFA_FAULT_SPACE;
                        d.irq_status[`MFA_IRQ_DONE] = 1'b1;
                        d.irq_status[`MFA_IRQ_FAULT] = 1'b1;
                    end else if (!q.dir || q.field_bit_count < width_of(q.w32)) begin
                        // A partial field write is read-modify-write
                        d.fsm = S_RDREQ;
                        d.rmw = q.dir;
                        d.req_func = (q.space == `MFA_SP_INP) ? `MFA_FC_RD_INP : `MFA_FC_RD_HOLD;
                        d.req_qty = q.w32 ? `MFA_QTY2 : `MFA_QTY1;
                        d.req_hi = 16'h0000;
                        d.req_lo = 16'h0000;
                    end else begin
                        d.fsm = S_WRREQ;
                        d.rmw = 1'b0;
                        {d.req_func, d.req_qty, d.req_hi, d.req_lo} = wr_req(q.w32, q.force_multi_write, q.wdata);
                    end
                end
            end
            S_RDREQ: begin
                if (lnk_req_ready) begin
                    d.fsm = S_RDWAIT;
                end
            end
            S_WRREQ: begin
                if (lnk_req_ready) begin
                    d.fsm = S_WRWAIT;
                end
            end
            S_RDWAIT, S_WRWAIT: begin
                if (rsp_bad) begin
                    d.fsm = S_IDLE;
                    d.reading_valid_flag = 1'b0;
                    d.fault_code = lnk_rsp_code;
                    d.irq_status[`MFA_IRQ_DONE] = 1'b1;
                    d.irq_status[`MFA_IRQ_FAULT] = 1'b1;
                end else if (rd_ok && q.rmw) begin
                    d.fsm = S_WRREQ;
                    {d.req_func, d.req_qty, d.req_hi, d.req_lo} = wr;
                end else if (rsp_take) begin
                    d.fsm = S_IDLE;
                    d.reading_valid_flag = 1'b1;
                    d.fault_code = `MFA_FAULT_NONE;
                    d.irq_status[`MFA_IRQ_DONE] = 1'b1;
                    if (rd_ok) begin
                        d.unprocessed_reading = rsp_word;
                        d.value = fld_val;
                    end else begin
                        d.unprocessed_reading = {d.req_hi, d.req_lo} >> (q.w32 ? 5'd0 : 5'd16);
                        d.value = (q.wdata & mfa_mask(q.field_bit_count));
                    end
                end
            end
            // Non one-hot code, e.g. before the first reset
            default: begin
                d.fsm = S_IDLE;
            end
        endcase
        if (rst) begin
            d = '0;
            d.fsm = S_IDLE;
            d.field_bit_count = `MFA_W16;
        end
    end

    always_ff @(posedge sys_clk) begin
        q <= d;
    end

    assign s_axi_awready = !q.aw_have && !q.bvalid;
    assign s_axi_wready = !q.w_have && !q.bvalid;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign lnk_req_valid = (q.fsm == S_RDREQ) || (q.fsm == S_WRREQ);
    assign lnk_req_func = q.req_func;
    assign lnk_req_addr = q.reg_addr;
    assign lnk_req_qty = q.req_qty;
    assign lnk_req_data_hi = q.req_hi;
    assign lnk_req_data_lo = q.req_lo;
    assign irq = |(q.irq_status & q.irq_mask);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_cnt16;
        !q.w32 |-> q.field_bit_count <= `MFA_W16;
    endproperty
    a_cnt16: assert property (p_cnt16) else $error("bit count above 16");
    property p_zero_cnt;
        fld_acc && fv[`MFA_FLD_CNT] == '0 |=> q.field_bit_count == width_of(q.w32);
    endproperty
    a_zero_cnt: assert property (p_zero_cnt) else $error("zero count not widened");
    property p_pos16;
        !q.w32 |-> q.field_start_bit < `MFA_W16;
    endproperty
    a_pos16: assert property (p_pos16) else $error("start bit above 15");
    property p_fit;
        ({1'b0, q.field_bit_count} + {1'b0, q.field_start_bit}) <= {1'b0, width_of(q.w32)};
    endproperty
    a_fit: assert property (p_fit) else $error("field exceeds width");
    property p_zero_pos;
        fld_acc && fv[`MFA_FLD_CNT] == '0 |=> q.field_start_bit == '0;
    endproperty
    a_zero_pos: assert property (p_zero_pos) else $error("start not cleared");
    property p_extract;
        rd_ok && !q.rmw |=> q.value == ((q.unprocessed_reading >> q.field_start_bit) & mfa_mask(q.field_bit_count));
    endproperty
    a_extract: assert property (p_extract) else $error("field extract wrong");
    property p_fc04;
        q.fsm == S_RDREQ && q.space == `MFA_SP_INP |-> lnk_req_func == `MFA_FC_RD_INP;
    endproperty
    a_fc04: assert property (p_fc04) else $error("input read code");
    property p_fc06;
        q.fsm == S_WRREQ && !q.w32 && !q.force_multi_write |-> lnk_req_func == `MFA_FC_WR_ONE && lnk_req_qty == `MFA_QTY1;
    endproperty
    a_fc06: assert property (p_fc06) else $error("single write code");
    property p_fc03;
        q.fsm == S_RDREQ && q.space == `MFA_SP_HOLD |-> lnk_req_func == `MFA_FC_RD_HOLD;
    endproperty
    a_fc03: assert property (p_fc03) else $error("holding read code");
    property p_fc16;
        q.fsm == S_WRREQ && q.w32 |-> lnk_req_func == `MFA_FC_WR_MULTI && lnk_req_qty == `MFA_QTY2;
    endproperty
    a_fc16: assert property (p_fc16) else $error("32-bit write code");
    property p_be;
        rd_ok && q.w32 && !q.rmw |=> q.unprocessed_reading == {$past(lnk_rsp_data_hi), $past(lnk_rsp_data_lo)};
    endproperty
    a_be: assert property (p_be) else $error("word order wrong");
    property p_force;
        q.fsm == S_WRREQ && !q.w32 && q.force_multi_write |-> lnk_req_func == `MFA_FC_WR_MULTI;
    endproperty
    a_force: assert property (p_force) else $error("forced multi write");
    property p_fault;
        rsp_bad |=> !q.reading_valid_flag && q.fault_code == $past(lnk_rsp_code) && q.fsm == S_IDLE;
    endproperty
    a_fault: assert property (p_fault) else $error("fault not recorded");
    c_read: cover property (rd_ok && !q.rmw);
    c_rmw: cover property (rd_ok && q.rmw ##[1:20] q.fsm == S_WRWAIT);
    c_fault: cover property (rsp_bad);
    c_irq: cover property (irq);
endmodule

// file: mfa_field_unit.sv
// Bit field extract and insert on a 32-bit value.
// Assumes start and count already fit the value width.
`timescale 1ns/100ps
module mfa_field_unit import mfa_pkg::*; (
    input wire logic [31:0] raw,
    input wire logic [5:0] start,
    input wire logic [5:0] count,
    input wire logic [31:0] ins,
    output logic [31:0] extracted,
    output logic [31:0] merged
);
    logic [31:0] m;

    always_comb begin
        m = mfa_mask(count);
        extracted = (raw >> start) & m;
        merged = (raw & ~(m << start)) | ((ins & m) << start);
    end
endmodule

// file: mfa_pkg.sv
// Types and the field mask helper of the field access engine.
// Assumes mfa_defines.svh is on the include path.
`include "mfa_defines.svh"
package mfa_pkg;

    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_RDREQ = 5'b00010,
        S_RDWAIT = 5'b00100,
        S_WRREQ = 5'b01000,
        S_WRWAIT = 5'b10000
    } mfa_state_t;

    typedef struct packed {
        mfa_state_t fsm;
        logic go;
        logic rmw;
        logic dir;
        logic [1:0] space;
        logic w32;
        logic force_multi_write;
        logic [1:0] value_format;
        logic [5:0] field_bit_count;
        logic [5:0] field_start_bit;
        logic [15:0] reg_addr;
        logic [31:0] wdata;
        logic [31:0] value;
        logic [31:0] unprocessed_reading;
        logic reading_valid_flag;
        logic [7:0] fault_code;
        logic [2:0] irq_status;
        logic [2:0] irq_mask;
        logic aw_have;
        logic [7:0] awaddr;
        logic w_have;
        logic [31:0] wdat;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] req_func;
        logic [1:0] req_qty;
        logic [15:0] req_hi;
        logic [15:0] req_lo;
    } mfa_regs_t;

    function automatic logic [31:0] mfa_mask(input logic [5:0] c);
        if (c >= `MFA_W32) begin
            return '1;
        end
        return (32'h1 << c) - 32'h1;
    endfunction

endpackage

// file: mfa_slave_model.sv
// Far-side register slave answering the engine's link requests.
// Assumes one request at a time; keeps a 16-word register image.
`timescale 1ns/100ps
module mfa_slave_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic lnk_req_valid,
    output logic lnk_req_ready,
    input wire logic [7:0] lnk_req_func,
    input wire logic [15:0] lnk_req_addr,
    input wire logic [1:0] lnk_req_qty,
    input wire logic [15:0] lnk_req_data_hi,
    input wire logic [15:0] lnk_req_data_lo,
    output logic lnk_rsp_valid,
    output logic lnk_rsp_error,
    output logic [7:0] lnk_rsp_code,
    output logic [15:0] lnk_rsp_data_hi,
    output logic [15:0] lnk_rsp_data_lo,
    input wire logic [3:0] delay,
    input wire logic fail
);
    logic [15:0] mem [16];
    logic [7:0] last_func;
    logic [1:0] last_qty;
    logic [15:0] last_hi;
    logic [15:0] last_lo;
    logic [3:0] a;
    logic [3:0] cnt;
    logic pend;
    initial foreach (mem[i]) mem[i] = 16'h0;
    // One request outstanding, so ready only while idle
    assign lnk_req_ready = !pend;
    always @(posedge sys_clk) begin
        // Lines toggle outside answers so stale data never looks valid
        lnk_rsp_valid <= 1'b0;
        lnk_rsp_error <= ~lnk_rsp_error;
        lnk_rsp_data_hi <= ~lnk_rsp_data_hi;
        lnk_rsp_data_lo <= ~lnk_rsp_data_lo;
        if (rst) begin
            pend <= 1'b0;
            lnk_rsp_error <= 1'b0;
            lnk_rsp_code <= 8'h00;
            lnk_rsp_data_hi <= 16'h0;
            lnk_rsp_data_lo <= 16'h0;
        end else if (pend && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else if (pend) begin
            pend <= 1'b0;
            lnk_rsp_valid <= 1'b1;
            lnk_rsp_error <= fail;
            lnk_rsp_code <= fail ? 8'h0b : 8'h00;
            if (!fail && last_func == 8'h06) mem[a] <= last_hi;
            if (!fail && last_func == 8'h10) begin
                mem[a] <= last_hi;
                if (last_qty == 2'h2) mem[a + 4'h1] <= last_lo;
            end
            // Input space answers inverted so 03 and 04 differ
            lnk_rsp_data_hi <= last_func == 8'h04 ? ~mem[a] : mem[a];
            lnk_rsp_data_lo <= last_func == 8'h04 ? ~mem[a + 4'h1] : mem[a + 4'h1];
        end else if (lnk_req_valid) begin
            pend <= 1'b1;
            cnt <= delay;
            a <= lnk_req_addr[3:0];
            last_func <= lnk_req_func;
            last_qty <= lnk_req_qty;
            last_hi <= lnk_req_data_hi;
            last_lo <= lnk_req_data_lo;
        end
    end
endmodule

// file: modbus_field_access_tb.sv
// Self-checking bench for the field access engine over AXI4-Lite.
// Assumes mfa_defines.svh on the include path and the slave model.
`timescale 1ns/100ps
`include "mfa_defines.svh"
module modbus_field_access_tb;
    logic sys_clk, rst, irq;
    logic [7:0] s_axi_awaddr, s_axi_araddr, lnk_req_func, lnk_rsp_code;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb, delay;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, fail;
    logic [1:0] s_axi_bresp, s_axi_rresp, lnk_req_qty, rr;
    logic lnk_req_valid, lnk_req_ready, lnk_rsp_valid, lnk_rsp_error;
    logic [15:0] lnk_req_addr, lnk_req_data_hi, lnk_req_data_lo, lnk_rsp_data_hi, lnk_rsp_data_lo;
    int err_total, n_compared, cycles;
    mfa_field_access uut (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .lnk_req_valid, .lnk_req_ready, .lnk_req_func, .lnk_req_addr, .lnk_req_qty,
        .lnk_req_data_hi, .lnk_req_data_lo, .lnk_rsp_valid, .lnk_rsp_error, .lnk_rsp_code,
        .lnk_rsp_data_hi, .lnk_rsp_data_lo, .irq);
    mfa_slave_model sl (.sys_clk, .rst, .lnk_req_valid, .lnk_req_ready, .lnk_req_func, .lnk_req_addr,
        .lnk_req_qty, .lnk_req_data_hi, .lnk_req_data_lo, .lnk_rsp_valid, .lnk_rsp_error, .lnk_rsp_code,
        .lnk_rsp_data_hi, .lnk_rsp_data_lo, .delay, .fail);
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Sequence needs well under 20000 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            summarize();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // Handshakes judged at the negedge: same values the next rising edge samples
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        tb = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!tb) begin
            @(negedge sys_clk);
            ta = s_axi_awready;
            tw = s_axi_wready;
            tb = s_axi_bvalid;
            rr = s_axi_bresp;
            @(posedge sys_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
    endtask
    task automatic rd(input logic [7:0] a);
        logic ta, tr;
        tr = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        while (!tr) begin
            @(negedge sys_clk);
            ta = s_axi_arready;
            tr = s_axi_rvalid;
            rv = s_axi_rdata;
            rr = s_axi_rresp;
            @(posedge sys_clk);
            if (ta) s_axi_arvalid <= 1'b0;
        end
    endtask
    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(n, e, rv);
    endtask
    task automatic ci(input logic e);
        @(negedge sys_clk);
        chk("irq", {31'h0, e}, {31'h0, irq});
        @(posedge sys_clk);
    endtask
    task automatic cl(input logic [7:0] f, input logic [1:0] q);
        chk("func", {24'h0, f}, {24'h0, sl.last_func});
        chk("qty", {30'h0, q}, {30'h0, sl.last_qty});
    endtask
    task automatic op(input logic [31:0] c, input logic [31:0] f);
        wr(`MFA_A_CTRL, c);
        wr(`MFA_A_FIELD, f);
        wr(`MFA_A_ISTAT, 32'h7);
        wr(`MFA_A_CTRL, c | 32'h1);
        rv = 32'h0;
        while (rv[`MFA_IRQ_DONE] !== 1'b1) begin
            rd(`MFA_A_ISTAT);
        end
    endtask
    initial begin
        {rst, s_axi_bready, s_axi_rready} = 3'b111;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, fail} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        delay = 4'h0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rc("field", `MFA_A_FIELD, 32'h10);
        rd(8'h24);
        chk("rresp", 32'h2, {30'h0, rr});
        wr(8'h24, 32'h0);
        chk("bresp", 32'h2, {30'h0, rr});
        wr(`MFA_A_ADDR, 32'h2);
        wr(`MFA_A_WDATA, 32'hc907);
        op(32'h0a, 32'h0);
        cl(8'h06, 2'h1);
        chk("hi", 32'hc907, {16'h0, sl.last_hi});
        chk("lo", 32'h0, {16'h0, sl.last_lo});
        rc("field", `MFA_A_FIELD, 32'h10);
        rc("raw", `MFA_A_RAW, 32'hc907);
        rc("result", `MFA_A_RESULT, 32'h1);
        delay <= 4'h5;
        wr(`MFA_A_ADDR, 32'h3);
        wr(`MFA_A_WDATA, 32'h1996);
        op(32'h2a, 32'h0);
        cl(8'h10, 2'h1);
        rc("ctrl", `MFA_A_CTRL, 32'h2a);
        delay <= 4'h0;
        wr(`MFA_A_ADDR, 32'h4);
        wr(`MFA_A_WDATA, 32'h20a11d00);
        op(32'h1a, 32'h20);
        cl(8'h10, 2'h2);
        chk("hilo", 32'h20a11d00, {sl.last_hi, sl.last_lo});
        op(32'h18, 32'h0f20);
        cl(8'h03, 2'h2);
        rc("field", `MFA_A_FIELD, 32'h0f11);
        rc("raw", `MFA_A_RAW, 32'h20a11d00);
        rc("value", `MFA_A_VALUE, (32'h20a11d00 >> 15) & 32'h1ffff);
        wr(`MFA_A_ADDR, 32'h2);
        op(32'h08, 32'h0f10);
        rc("field", `MFA_A_FIELD, 32'h0f01);
        rc("value", `MFA_A_VALUE, 32'h1);
        op(32'h0c, 32'h0500);
        cl(8'h04, 2'h1);
        rc("field", `MFA_A_FIELD, 32'h10);
        rc("value", `MFA_A_VALUE, 32'h36f8);
        wr(`MFA_A_WDATA, 32'ha);
        op(32'h0a, 32'h0404);
        cl(8'h06, 2'h1);
        chk("hi", 32'hc9a7, {16'h0, sl.last_hi});
        wr(`MFA_A_ISTAT, 32'h7);
        wr(`MFA_A_FIELD, 32'h11);
        rc("field", `MFA_A_FIELD, 32'h0404);
        rc("istat", `MFA_A_ISTAT, 32'h4);
        wr(`MFA_A_FIELD, 32'h1001);
        rc("field", `MFA_A_FIELD, 32'h0404);
        ci(1'b0);
        wr(`MFA_A_IMASK, 32'h4);
        ci(1'b1);
        wr(`MFA_A_ISTAT, 32'h4);
        ci(1'b0);
        fail <= 1'b1;
        op(32'h08, 32'h0);
        rc("result", `MFA_A_RESULT, 32'h0b00);
        rc("istat", `MFA_A_ISTAT, 32'h3);
        fail <= 1'b0;
        op(32'h0e, 32'h0);
        rc("result", `MFA_A_RESULT, 32'hf000);
        summarize();
    end
endmodule
